// ==== design/wwdr_pkg.sv ====
package wwdr_pkg;

    localparam int CLK_PERIOD_NS      = 8;
    localparam int WDRST_PULSE_NS     = 1000;
    localparam int WDRST_PULSE_CYCLES = (WDRST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // register indices; byte address is four times the index
    localparam logic [9:0] BASE_BLOCKING    = 10'h200;
    localparam logic [9:0] BASE_NONBLOCKING = 10'h300;
    localparam logic [7:0] OFF_CTL          = 8'h10;
    localparam logic [7:0] OFF_STAT         = 8'h12;
    localparam logic [7:0] OFF_REARM        = 8'h14;
    localparam logic [7:0] OFF_IRQ_STAT     = 8'h18;
    localparam logic [7:0] OFF_IRQ_MASK     = 8'h19;

    localparam int CTL_TEST_MASK_POS = 15;
    localparam int CTL_TO_MASK_LSB   = 8;
    localparam int CTL_TEST_POS      = 7;
    localparam int CTL_TO_LSB        = 0;
    localparam int STAT_OFF_POS      = 1;
    localparam int STAT_WO_POS       = 0;

    localparam logic [2:0] TO_OFF     = 3'h0;
    localparam logic [2:0] TO_RESET   = 3'h4;
    localparam logic       TEST_RESET = 1'b1;

    localparam logic [7:0] REARM_FIRST  = 8'haa;
    localparam logic [7:0] REARM_SECOND = 8'h55;

    localparam int TO1_MS = 4;
    localparam int TO2_MS = 16;
    localparam int TO3_MS = 64;
    localparam int TO4_MS = 256;
    localparam int TO5_MS = 512;
    localparam int TO6_MS = 1024;
    localparam int TO7_MS = 2048;
    localparam int INIT_TO_MS = TO4_MS;

    localparam int IRQ_W           = 3;
    localparam int IRQ_WINDOW_OPEN = 0;
    localparam int IRQ_TIMEOUT     = 1;
    localparam int IRQ_BAD_REARM   = 2;

    typedef enum logic [1:0] {ST_INIT, ST_WINDOW, ST_OFF, ST_SLEEP} wwdr_state_t;

    typedef struct packed {
        logic       testBit;
        logic [2:0] timeoutSelect;
    } wwdr_ctl_t;

    localparam wwdr_ctl_t CTL_RESET = '{testBit: TEST_RESET, timeoutSelect: TO_RESET};

    typedef struct packed {
        logic disabledFlag;
        logic windowOpenFlag;
    } wwdr_stat_t;

endpackage : wwdr_pkg

// ==== design/wwdr_lp_tick.sv ====
`timescale 1ns/10ps
module wwdr_lp_tick (
    input  wire logic core_clk,
    input  wire logic reset_n,
    input  wire logic lpClkIn,
    input  wire logic lowPowerIn,
    output logic      lpTick,
    output logic      lowPowerSync
);
    // bit 0 oscillator clock, bit 1 low-power request
    logic [1:0] stage1_reg;
    logic [1:0] stage2_reg;
    logic       lpLast_reg;
    logic       tick_reg;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1_reg <= 2'h0;
            stage2_reg <= 2'h0;
            lpLast_reg <= 1'b0;
            tick_reg   <= 1'b0;
        end else begin
            stage1_reg <= {lowPowerIn, lpClkIn};
            stage2_reg <= stage1_reg;
            lpLast_reg <= stage2_reg[0];
            tick_reg   <= stage2_reg[0] & ~lpLast_reg;
        end
    end

    assign lpTick       = tick_reg;
    assign lowPowerSync = stage2_reg[1];

endmodule : wwdr_lp_tick

// ==== design/wwdr_top.sv ====
// Operation
// - control register takes full 16-bit writes only
// - test bit written only with test mask
// - timeout select written only where mask set
// - test bit has no watchdog effect
// - timeout select picks off or seven periods
// - reset: period 256 ms, test bit one
// - status bit 1 reads watchdog off
// - status bit 0 reads window open
// - refresh with window closed forces reset
// - alternating 0xaa/0x55 in window clears counter
// - rearm writes ignored while disabled
// - decode offsets at two base addresses
// - status register read-only, upper bits zero
// - initial fixed 256 ms watchdog needs 0xaa
// - window: first half forbidden, second half allowed
// - off only on first control write; code allows it until a period other than 256 ms is set or a rearm is accepted
// - low power: off, restart as power-on
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/10ps
module wwdr_top
    import wwdr_pkg::*;
#(
    parameter int LP_TICKS_PER_MS = 32
) (
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic [11:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        lowPowerOscClock,
    input  wire logic        lowPowerMode,
    output logic             watchdogReset,
    output logic             irq
);
    localparam int CNT_W = $clog2(TO7_MS * LP_TICKS_PER_MS + 1);

    if (LP_TICKS_PER_MS < 2 || LP_TICKS_PER_MS > 4096) begin : g_bad_ticks
        $error("LP_TICKS_PER_MS out of range");
    end

    function automatic logic [CNT_W-1:0] period_ticks(input logic [2:0] sel);
        int ms;
        case (sel)
            3'h1:    ms = TO1_MS;
            3'h2:    ms = TO2_MS;
            3'h3:    ms = TO3_MS;
            3'h4:    ms = TO4_MS;
            3'h5:    ms = TO5_MS;
            3'h6:    ms = TO6_MS;
            3'h7:    ms = TO7_MS;
            default: ms = 0;
        endcase
        return CNT_W'(ms * LP_TICKS_PER_MS);
    endfunction : period_ticks

    logic lpTick;
    logic lpSync;

    wwdr_lp_tick u_lp_tick (
        .core_clk     (core_clk),
        .reset_n      (reset_n),
        .lpClkIn      (lowPowerOscClock),
        .lowPowerIn   (lowPowerMode),
        .lpTick       (lpTick),
        .lowPowerSync (lpSync)
    );

    wwdr_state_t      state_reg,    state_next;
    wwdr_ctl_t        ctl_reg,      ctl_next;
    logic [CNT_W-1:0] cnt_reg,      cnt_next;
    logic             expectAa_reg, expectAa_next;
    logic             offOk_reg,    offOk_next;
    logic             winPrev_reg,  winPrev_next;
    logic [7:0]       rstCnt_reg,   rstCnt_next;
    logic             wdRst_reg,    wdRst_next;
    logic [IRQ_W-1:0] irqStat_reg,  irqStat_next;
    logic [IRQ_W-1:0] irqMask_reg,  irqMask_next;
    logic             irq_reg,      irq_next;
    logic             wait_reg,     wait_next;
    logic [31:0]      rdata_reg,    rdata_next;

    logic [9:0]       idx;
    logic [7:0]       off;
    logic             mapped;
    logic             take;
    logic             wrCtl;
    logic             wrRearm;
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] cntInc;
    logic             winOpen;
    wwdr_stat_t       stat;
    logic [2:0]       toMask;
    logic [2:0]       toCand;
    logic [7:0]       rearmVal;
    logic             timeoutEvt;
    logic             badRearmEvt;
    logic             goodRearm;

    always_comb begin
        idx    = avs_address[11:2];
        off    = idx[7:0];
        mapped = (idx[9:8] == BASE_BLOCKING[9:8]) || (idx[9:8] == BASE_NONBLOCKING[9:8]);
        take   = (avs_read || avs_write) && wait_reg && mapped;
        wrCtl   = take && avs_write && off == OFF_CTL && avs_byteenable[1:0] == 2'h3;
        wrRearm = take && avs_write && off == OFF_REARM && avs_byteenable[0];
        period  = (state_reg == ST_INIT) ? period_ticks(TO_RESET)
                                         : period_ticks(ctl_reg.timeoutSelect);
        cntInc  = cnt_reg + CNT_W'(1);
        case (state_reg)
            ST_INIT:   winOpen = 1'b1;
            ST_WINDOW: winOpen = cnt_reg >= (period >> 1);
            default:   winOpen = 1'b0;
        endcase
        stat.windowOpenFlag = winOpen;
        stat.disabledFlag   = state_reg == ST_OFF || state_reg == ST_SLEEP;
        toMask   = avs_writedata[CTL_TO_MASK_LSB +: 3];
        toCand   = (ctl_reg.timeoutSelect & ~toMask) | (avs_writedata[CTL_TO_LSB +: 3] & toMask);
        rearmVal = avs_writedata[7:0];

        state_next    = state_reg;
        ctl_next      = ctl_reg;
        cnt_next      = cnt_reg;
        expectAa_next = expectAa_reg;
        offOk_next    = offOk_reg;
        timeoutEvt    = 1'b0;
        badRearmEvt   = 1'b0;
        goodRearm     = 1'b0;

        // counter advances only on synchronised oscillator edges
        if ((state_reg == ST_INIT || state_reg == ST_WINDOW) && lpTick) begin
            cnt_next = cntInc;
            if (cntInc >= period) begin
                timeoutEvt = 1'b1;
            end
        end

        if (wrCtl) begin
            if (avs_writedata[CTL_TEST_MASK_POS]) begin
                ctl_next.testBit = avs_writedata[CTL_TEST_POS];
            end
            if (toCand == TO_OFF) begin
                if (offOk_reg && state_reg != ST_SLEEP) begin
                    ctl_next.timeoutSelect = TO_OFF;
                    state_next             = ST_OFF;
                end
            end else begin
                ctl_next.timeoutSelect = toCand;
                if (toCand != TO_RESET) begin
                    offOk_next = 1'b0;
                end
                if (state_reg == ST_OFF) begin
                    state_next    = ST_INIT;
                    cnt_next      = '0;
                    expectAa_next = 1'b1;
                end
            end
        end

        if (wrRearm) begin
            case (state_reg)
                ST_INIT: begin
                    if (rearmVal == REARM_FIRST) begin
                        goodRearm = 1'b1;
                    end else begin
                        badRearmEvt = 1'b1;
                    end
                end
                ST_WINDOW: begin
                    if (!winOpen || rearmVal != (expectAa_reg ? REARM_FIRST : REARM_SECOND)) begin
                        badRearmEvt = 1'b1;
                    end else begin
                        goodRearm = 1'b1;
                    end
                end
                default: ;
            endcase
        end

        if (goodRearm) begin
            cnt_next      = '0;
            expectAa_next = ~expectAa_reg;
            offOk_next    = 1'b0;
            state_next    = ST_WINDOW;
        end

        // a violation or leaving low power restarts as after power-on
        if (lpSync) begin
            state_next = ST_SLEEP;
            cnt_next   = '0;
        end else if (timeoutEvt || badRearmEvt || state_reg == ST_SLEEP) begin
            state_next    = ST_INIT;
            ctl_next      = CTL_RESET;
            cnt_next      = '0;
            expectAa_next = 1'b1;
            offOk_next    = 1'b1;
        end
    end

    always_comb begin
        wait_next  = 1'b1;
        rdata_next = rdata_reg;
        if ((avs_read || avs_write) && wait_reg) begin
            wait_next  = 1'b0;
            rdata_next = 32'h0;
            if (avs_read && mapped) begin
                case (off)
                    OFF_CTL: begin
                        rdata_next[CTL_TEST_POS]    = ctl_reg.testBit;
                        rdata_next[CTL_TO_LSB +: 3] = ctl_reg.timeoutSelect;
                    end
                    OFF_STAT:     rdata_next[1:0] = stat;
                    OFF_IRQ_STAT: rdata_next[IRQ_W-1:0] = irqStat_reg;
                    OFF_IRQ_MASK: rdata_next[IRQ_W-1:0] = irqMask_reg;
                    default:      rdata_next = 32'h0;
                endcase
            end
        end
    end

    always_comb begin
        winPrev_next = winOpen && state_reg == ST_WINDOW;
        irqStat_next = irqStat_reg;
        if (take && avs_read && off == OFF_IRQ_STAT) begin
            irqStat_next = '0;
        end
        // set beats the read-clear in the same cycle
        irqStat_next[IRQ_WINDOW_OPEN] |= winPrev_next && !winPrev_reg;
        irqStat_next[IRQ_TIMEOUT]     |= timeoutEvt && !lpSync;
        irqStat_next[IRQ_BAD_REARM]   |= badRearmEvt && !lpSync;
        irqMask_next = irqMask_reg;
        if (take && avs_write && off == OFF_IRQ_MASK && avs_byteenable[0]) begin
            irqMask_next = avs_writedata[IRQ_W-1:0];
        end
        irq_next    = |(irqStat_next & irqMask_next);
        rstCnt_next = (rstCnt_reg != 8'h0) ? rstCnt_reg - 8'h1 : 8'h0;
        if ((timeoutEvt || badRearmEvt) && !lpSync) begin
            rstCnt_next = 8'(WDRST_PULSE_CYCLES);
        end
        wdRst_next = rstCnt_next != 8'h0;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg    <= ST_INIT;
            ctl_reg      <= CTL_RESET;
            cnt_reg      <= '0;
            expectAa_reg <= 1'b1;
            offOk_reg    <= 1'b1;
            winPrev_reg  <= 1'b0;
            rstCnt_reg   <= 8'h0;
            wdRst_reg    <= 1'b0;
            irqStat_reg  <= '0;
            irqMask_reg  <= '0;
            irq_reg      <= 1'b0;
            wait_reg     <= 1'b1;
            rdata_reg    <= 32'h0;
        end else begin
            state_reg    <= state_next;
            ctl_reg      <= ctl_next;
            cnt_reg      <= cnt_next;
            expectAa_reg <= expectAa_next;
            offOk_reg    <= offOk_next;
            winPrev_reg  <= winPrev_next;
            rstCnt_reg   <= rstCnt_next;
            wdRst_reg    <= wdRst_next;
            irqStat_reg  <= irqStat_next;
            irqMask_reg  <= irqMask_next;
            irq_reg      <= irq_next;
            wait_reg     <= wait_next;
            rdata_reg    <= rdata_next;
        end
    end

    assign avs_readdata    = rdata_reg;
    assign avs_waitrequest = wait_reg;
    assign watchdogReset   = wdRst_reg;
    assign irq             = irq_reg;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence s_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    property p_bus_answer;
        (avs_read || avs_write) && avs_waitrequest |=> s_answer;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("no one-cycle answer");

    property p_ctl_byte_ignored;
        take && avs_write && off == OFF_CTL && avs_byteenable[1:0] != 2'h3 && !lpSync
            && !timeoutEvt && state_reg != ST_SLEEP |=> ctl_reg == $past(ctl_reg);
    endproperty
    a_ctl_byte_ignored: assert property (p_ctl_byte_ignored) else $error("byte write hit ctl");

    property p_test_masked;
        wrCtl && !avs_writedata[CTL_TEST_MASK_POS] && !timeoutEvt && !lpSync
            && state_reg != ST_SLEEP |=> ctl_reg.testBit == $past(ctl_reg.testBit);
    endproperty
    a_test_masked: assert property (p_test_masked) else $error("test bit changed unmasked");

    property p_to_masked;
        wrCtl && toMask == 3'h0 && !timeoutEvt && !badRearmEvt && !lpSync
            && state_reg != ST_SLEEP |=> ctl_reg.timeoutSelect == $past(ctl_reg.timeoutSelect);
    endproperty
    a_to_masked: assert property (p_to_masked) else $error("timeout changed unmasked");

    property p_timeout_reset;
        state_reg == ST_WINDOW && lpTick && cntInc >= period && !lpSync
            |=> watchdogReset && state_reg == ST_INIT;
    endproperty
    a_timeout_reset: assert property (p_timeout_reset) else $error("timeout without reset");

    property p_status_read;
        take && avs_read && off == OFF_STAT
            |=> avs_readdata == {30'h0, $past(stat.disabledFlag), $past(winOpen)};
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong");

    property p_closed_refresh;
        wrRearm && state_reg == ST_WINDOW && !winOpen && !lpSync |=> watchdogReset [*2];
    endproperty
    a_closed_refresh: assert property (p_closed_refresh) else $error("closed refresh ok");

    property p_good_rearm;
        goodRearm && !lpSync && !timeoutEvt
            |=> cnt_reg == '0 && expectAa_reg != $past(expectAa_reg);
    endproperty
    a_good_rearm: assert property (p_good_rearm) else $error("rearm did not clear");

    property p_off_rearm;
        wrRearm && state_reg == ST_OFF && !lpSync && !wrCtl
            |=> expectAa_reg == $past(expectAa_reg) && state_reg == ST_OFF;
    endproperty
    a_off_rearm: assert property (p_off_rearm) else $error("rearm acted while off");

    property p_off_locked;
        wrCtl && !offOk_reg && state_reg != ST_OFF |=> state_reg != ST_OFF;
    endproperty
    a_off_locked: assert property (p_off_locked) else $error("late off accepted");

    property p_sleep_off;
        lpSync |=> state_reg == ST_SLEEP ##0 stat.disabledFlag;
    endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("low power not off");

endmodule : wwdr_top

// ==== tb/wwdr_osc_model.sv ====
`timescale 1ns/10ps
module wwdr_osc_model #(
    parameter int HALF_NS  = 40,
    parameter int START_NS = 3
) (
    output logic lowPowerOscClock
);
    // free running; odd start offset keeps it out of phase with core_clk
    initial begin
        lowPowerOscClock = 1'b0;
        #(START_NS);
        forever #(HALF_NS) lowPowerOscClock = ~lowPowerOscClock;
    end
endmodule : wwdr_osc_model

// ==== tb/window_watchdog_registers_tb_top.sv ====
`timescale 1ns/10ps
module window_watchdog_registers_tb_top
    import wwdr_pkg::*;
;
    // two ticks per ms: 4 ms is 8 ticks, 256 ms is 512 ticks of 10 cycles
    localparam int LP_TPM = 2;
    localparam logic [11:0] A_CTL    = {BASE_BLOCKING + 10'(OFF_CTL), 2'b00};
    localparam logic [11:0] A_CTL_NB = {BASE_NONBLOCKING + 10'(OFF_CTL), 2'b00};
    localparam logic [11:0] A_STAT   = {BASE_BLOCKING + 10'(OFF_STAT), 2'b00};
    localparam logic [11:0] A_REARM  = {BASE_BLOCKING + 10'(OFF_REARM), 2'b00};
    localparam logic [11:0] A_IRQ_ST = {BASE_BLOCKING + 10'(OFF_IRQ_STAT), 2'b00};
    localparam logic [11:0] A_IRQ_MK = {BASE_BLOCKING + 10'(OFF_IRQ_MASK), 2'b00};
    localparam logic [11:0] A_NONE   = {BASE_BLOCKING + 10'h1f, 2'b00};

    typedef struct packed {
        logic        wr;
        logic [11:0] addr;
        logic [15:0] wdata;
        logic [3:0]  be;
        logic [7:0]  expRd;
    } wwdr_row_t;

    localparam wwdr_row_t ROWS [9] = '{
        '{1'b0, A_CTL,    16'h0000, 4'hf, 8'h84},
        '{1'b0, A_STAT,   16'h0000, 4'hf, 8'h01},
        '{1'b1, A_CTL,    16'h0007, 4'hf, 8'h84},  // no masks: nothing changes
        '{1'b1, A_CTL,    16'h8000, 4'hf, 8'h04},  // test bit cleared alone
        '{1'b1, A_CTL,    16'h0703, 4'h1, 8'h04},  // byte access dropped
        '{1'b1, A_STAT,   16'h00ff, 4'hf, 8'h01},
        '{1'b0, A_NONE,   16'h0000, 4'hf, 8'h00},
        '{1'b1, A_CTL_NB, 16'h0701, 4'hf, 8'h01},
        '{1'b1, A_IRQ_MK, 16'h0004, 4'hf, 8'h04}
    };

    logic        core_clk;
    logic        reset_n;
    logic [11:0] avsAddress;
    logic        avsRead;
    logic        avsWrite;
    logic [31:0] avsWritedata;
    logic [3:0]  avsByteenable;
    logic [31:0] avsReaddata;
    logic        avsWaitrequest;
    logic        lowPowerOscClock;
    logic        lowPowerMode;
    logic        watchdogReset;
    logic        irq;
    logic [31:0] rdData;
    int          errorCnt;
    int          testsRun;
    int          nCyc;

    wwdr_top #(.LP_TICKS_PER_MS(LP_TPM)) i_wwdr_top (
        .core_clk        (core_clk),
        .reset_n         (reset_n),
        .avs_address     (avsAddress),
        .avs_read        (avsRead),
        .avs_write       (avsWrite),
        .avs_writedata   (avsWritedata),
        .avs_byteenable  (avsByteenable),
        .avs_readdata    (avsReaddata),
        .avs_waitrequest (avsWaitrequest),
        .lowPowerOscClock(lowPowerOscClock),
        .lowPowerMode    (lowPowerMode),
        .watchdogReset   (watchdogReset),
        .irq             (irq)
    );

    wwdr_osc_model i_wwdr_osc_model (.lowPowerOscClock(lowPowerOscClock));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic finish_test;
        $display("checks %0d errors %0d", testsRun, errorCnt);
        if (errorCnt == 0 && testsRun > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string name, input logic [31:0] expV, input logic [31:0] gotV);
        testsRun++;
        if (gotV !== expV) begin
            errorCnt++;
            $display("[ERR] %s expected %h seen %h", name, expV, gotV);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc

    // request held until waitrequest is sampled low, then released
    task automatic bus(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                       input logic [3:0] be);
        @(posedge core_clk);
        avsAddress    <= addr;
        avsWritedata  <= wdata;
        avsByteenable <= be;
        avsWrite      <= wr;
        avsRead       <= ~wr;
        // no cycle limit here: a stuck slave is caught by the run watchdog
        do begin
            @(posedge core_clk);
        end while (avsWaitrequest !== 1'b0);
        rdData = avsReaddata;
        avsWrite <= 1'b0;
        avsRead  <= 1'b0;
    endtask : bus

    task automatic wr(input logic [11:0] addr, input logic [31:0] wdata);
        bus(1'b1, addr, wdata, 4'hf);
    endtask : wr

    task automatic rd(input logic [11:0] addr);
        bus(1'b0, addr, 32'h0, 4'hf);
    endtask : rd

    // n: cycles until the reset output rises; checks the pulse length too
    task automatic wait_rst(input int maxc, output int n);
        int hi;
        n = 0;
        hi = 0;
        while (watchdogReset !== 1'b1 && n < maxc) begin
            @(posedge core_clk);
            n++;
        end
        chk("watchdogReset rise", 32'h1, 32'(watchdogReset));
        while (watchdogReset === 1'b1 && hi < 300) begin
            @(posedge core_clk);
            hi++;
        end
        chk("watchdogReset pulse", 32'(WDRST_PULSE_CYCLES), 32'(hi));
    endtask : wait_rst

    initial begin
        // about 50k cycles, several times the longest expected run
        #400000;
        errorCnt++;
        $display("[ERR] run expected done seen hang");
        finish_test();
    end

    initial begin
        reset_n       = 1'b0;
        avsAddress    = 12'h000;
        avsRead       = 1'b0;
        avsWrite      = 1'b0;
        avsWritedata  = 32'h0;
        avsByteenable = 4'h0;
        lowPowerMode  = 1'b0;
        errorCnt      = 0;
        testsRun      = 0;
        repeat (4) @(posedge core_clk);
        reset_n <= 1'b1;
        foreach (ROWS[i]) begin
            if (ROWS[i].wr) begin
                bus(1'b1, ROWS[i].addr, 32'(ROWS[i].wdata), ROWS[i].be);
            end
            rd(ROWS[i].addr);
            chk("register row", 32'(ROWS[i].expRd), rdData);
        end
        // initial 0xaa enters window mode with the 4 ms period
        wr(A_REARM, 32'(REARM_FIRST));
        rd(A_STAT);
        chk("status first half", 32'h00, rdData);
        cyc(60);
        rd(A_STAT);
        chk("status second half", 32'h01, rdData);
        wr(A_REARM, 32'(REARM_SECOND));
        rd(A_STAT);
        chk("status after refresh", 32'h00, rdData);
        chk("no reset on refresh", 32'h0, 32'(watchdogReset));
        wr(A_REARM, 32'(REARM_FIRST));
        wait_rst(50, nCyc);
        chk("irq bad rearm", 32'h1, 32'(irq));
        rd(A_IRQ_ST);
        chk("irq status bad rearm", 32'h4, rdData & 32'h4);
        cyc(2);
        chk("irq after clear", 32'h0, 32'(irq));
        rd(A_CTL);
        chk("ctl after violation", 32'h84, rdData);
        // window timeout with no refresh
        wr(A_CTL, 32'h0701);
        wr(A_REARM, 32'(REARM_FIRST));
        wait_rst(200, nCyc);
        chk("window timeout span", 32'h1, 32'(nCyc >= 60 && nCyc <= 100));
        // first control write of 000 turns it off
        wr(A_CTL, 32'h0700);
        rd(A_STAT);
        chk("off flag set", 32'h2, rdData & 32'h2);
        wr(A_REARM, 32'h12);
        cyc(20);
        chk("rearm while off", 32'h0, 32'(watchdogReset));
        wr(A_CTL, 32'h0702);
        rd(A_STAT);
        chk("off flag cleared", 32'h0, rdData & 32'h2);
        wr(A_CTL, 32'h0700);
        rd(A_CTL);
        chk("late 000 ignored", 32'h82, rdData);
        // low power forces off, then a power-on style restart
        lowPowerMode <= 1'b1;
        cyc(10);
        rd(A_STAT);
        chk("off in low power", 32'h2, rdData & 32'h2);
        lowPowerMode <= 1'b0;
        cyc(10);
        rd(A_CTL);
        chk("ctl after wake", 32'h84, rdData);
        rd(A_STAT);
        chk("status after wake", 32'h01, rdData);
        // initial 256 ms watchdog runs out without 0xaa
        wait_rst(6000, nCyc);
        chk("initial timeout span", 32'h1, 32'(nCyc >= 4900 && nCyc <= 5200));
        // reset in mid-run
        wr(A_CTL, 32'h8001);
        reset_n <= 1'b0;
        cyc(4);
        chk("waitrequest in reset", 32'h1, 32'(avsWaitrequest));
        chk("watchdogReset in reset", 32'h0, 32'(watchdogReset));
        reset_n <= 1'b1;
        rd(A_CTL);
        chk("ctl after reset", 32'h84, rdData);
        finish_test();
    end
endmodule : window_watchdog_registers_tb_top
